// ### hdl/motion_io_cfg.svh
/*
 Holds register offsets, field positions, reset values and timing counts of the motion I/O map.
 Assumes it is included by bare name inside a package or at file scope; the guard skips repeats in one compile unit.
*/
`ifndef MOTION_IO_CFG_SVH
`define MOTION_IO_CFG_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define REG_INPUTS        12'h000
`define REG_OUTPUTS       12'h004
`define REG_OUT_SET       12'h008
`define REG_OUT_CLR       12'h00c
`define REG_FUNC_SEL_A    12'h010
`define REG_FUNC_SEL_B    12'h014
`define REG_CAPTURE_CTRL  12'h018
`define REG_POS_AXIS0     12'h01c
`define REG_POS_AXIS1     12'h020
`define REG_CAPT0_AXIS0   12'h024
`define REG_CAPT0_AXIS1   12'h028
`define REG_CAPT1_AXIS1   12'h02c
`define REG_CAPT_DIFF     12'h030
`define REG_WIN_LOW       12'h034
`define REG_WIN_HIGH      12'h038
`define REG_WIN_CTRL      12'h03c
`define REG_MON_TORQUE    12'h040
`define REG_MON_SPEED     12'h044
`define REG_MON_TVALUE    12'h048
`define REG_MON_CH0       12'h04c
`define REG_IRQ_STATUS    12'h050
`define REG_IRQ_MASK      12'h054
`define REG_CYCLE_CFG     12'h058
// ----------------------------------------
// Input and output numbers
// ----------------------------------------
`define IN_FWD_PROHIBIT   5'd18
`define IN_REV_PROHIBIT   5'd19
`define IN_REG_PIN        5'd22
`define OUT_LOCAL_FIRST   5'd8
`define OUT_MODE_SELECT   5'd16
`define OUT_GAIN_REDUCE   5'd17
// ----------------------------------------
// Interrupt status bits
// ----------------------------------------
`define IRQ_CAPT_AXIS0    0
`define IRQ_CAPT0_AXIS1   1
`define IRQ_CAPT1_AXIS1   2
`define IRQ_FWD_LIMIT     3
`define IRQ_REV_LIMIT     4
`define IRQ_CYCLE         5
`define IRQ_WIDTH         6
// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define FUNC_SEL_RESET    32'hffff_ffff
`define CLK_PERIOD_NS     8
`define CYCLE_SHORT_US    500
`define CYCLE_LONG_US     1000
`define CYCLE_SHORT_CLKS  ((`CYCLE_SHORT_US * 1000) / `CLK_PERIOD_NS)
`define CYCLE_LONG_CLKS   ((`CYCLE_LONG_US * 1000) / `CLK_PERIOD_NS)
`endif

// ### hdl/motion_io_pkg.sv
/*
 Holds the types shared by the motion I/O map.
 Assumes motion_io_cfg.svh is on the include path.
*/
package motion_io_pkg;
  `include "motion_io_cfg.svh"
  typedef struct packed {
    logic [6:0] din;
    logic       alarm;
    logic       warning;
    logic       speed_conformity;
    logic       rotation_detected;
    logic       ready;
    logic       current_limit_flag;
    logic       speed_limit_flag;
    logic       servo_on_complete;
  } driver_status_t;
  typedef struct packed {
    logic [15:0] torque_command_monitor;
    logic [15:0] motor_speed_monitor;
    logic [15:0] torque_value_monitor;
    logic [15:0] monitor_channel_0;
  } monitor_t;
  typedef enum logic [2:0] {
    CAPT_IDLE  = 3'b001,
    CAPT_ARMED = 3'b010,
    CAPT_DONE  = 3'b100
  } capt_state_t;
endpackage : motion_io_pkg

// ### hdl/capture_unit.sv
/*
 Holds one armable position capture channel.
 Assumes trigger is a synchronised single-cycle pulse on pclk.
*/
`timescale 1ns/100ps
module capture_unit #(
  parameter int POS_W = 32
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             ce,
  input  wire logic             arm,
  input  wire logic             trigger,
  input  wire logic [POS_W-1:0] position,
  output logic                  captured,
  output logic                  done,
  output logic      [POS_W-1:0] value
);
  typedef struct packed {
    motion_io_pkg::capt_state_t state;
    logic [POS_W-1:0]           value;
    logic                       pulse;
  } st_t;
  st_t s_q;
  st_t s_d;
  always_comb begin
    s_d       = s_q;
    s_d.pulse = 1'b0;
    unique case (s_q.state)
      motion_io_pkg::CAPT_IDLE,
      motion_io_pkg::CAPT_DONE: begin
        if (arm) begin
          s_d.state = motion_io_pkg::CAPT_ARMED;
        end
      end
      motion_io_pkg::CAPT_ARMED: begin
        if (trigger) begin
          s_d.value = position;
          s_d.pulse = 1'b1;
          s_d.state = motion_io_pkg::CAPT_DONE;
        end
      end
      default: s_d.state = motion_io_pkg::CAPT_IDLE;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '{state: motion_io_pkg::CAPT_IDLE, value: '0, pulse: 1'b0};
    end else if (ce) begin
      s_q <= s_d;
    end
  end
  assign captured = s_q.pulse;
  assign done     = (s_q.state == motion_io_pkg::CAPT_DONE);
  assign value    = s_q.value;
endmodule : capture_unit

// ### hdl/motion_io_map.sv
/*
 Holds the motion I/O map: input numbers, outputs, capture, limits, monitors and the APB register file.
 Assumes an APB master on pclk; the driver status pins and the encoder index are asynchronous and synchronised here.
*/
// The APB slave port and the register addresses were left to the implementer.
// Operation
// (RULE1) Inputs 0-7 local, all inputs read through one input register.
// (RULE2) Each motion function picks any input number via a select field; only the limit selects are decoded, and act only at 18 and 19.
// (RULE3) Driver inputs mirrored at 16-22; 18, 19 prohibits, 22 registration.
// (RULE4) Driver status at 24-31: alarm, warning, conformity, rotation, ready, limits, servo on.
// (RULE5) Armed capture latches axis position at once on index or input.
// (RULE6) Axis 0 capture happens in the driver, on index or its pin.
// (RULE7) Driver latch allocation code 6 rising edge, F falling edge.
// (RULE8) Axis 1 capture source: local input 0, input 1, or index.
// (RULE9) Axis 1 has two capture registers and their difference.
// (RULE10) Limit selects 18 and 19 make prohibits the limits; act on them.
// (RULE11) Outputs 8-13 user driven, switched by a position window.
// (RULE12) Output 16 mode select: low speed, high torque.
// (RULE13) Output 17 gain reduce: low PI, high P only.
// (RULE14) Monitor channels hold torque command, speed, torque value.
// (RULE15) Driver data exchanged once per cycle, 500 or 1000 us, after reset.
// (RULE16) Reads give newest sample; writes to input-only numbers are ignored.
`timescale 1ns/100ps
module motion_io_map #(
  parameter int POS_W       = 32,
  parameter int CYCLE_SHORT = `CYCLE_SHORT_CLKS,
  parameter int CYCLE_LONG  = `CYCLE_LONG_CLKS
) (
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  input  wire logic                         ce,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [11:0]                  paddr,
  input  wire logic [31:0]                  pwdata,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  input  wire logic [7:0]                   local_in,
  input  wire logic                         encoder_index,
  input  wire motion_io_pkg::driver_status_t driver_in,
  input  wire motion_io_pkg::monitor_t       monitor_in,
  input  wire logic                         driver_latch,
  input  wire logic [POS_W-1:0]             driver_latch_pos,
  input  wire logic [POS_W-1:0]             axis0_pos,
  input  wire logic [POS_W-1:0]             axis1_pos,
  output logic      [5:0]                   local_out,
  output logic                              control_mode_select,
  output logic                              gain_reduce,
  output logic                              driver_capture_arm,
  output logic                              driver_capture_use_pin,
  output logic                              forward_limit_hit,
  output logic                              reverse_limit_hit,
  output logic                              cycle_tick,
  output logic                              irq
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [31:0]                  sync1;
    logic [31:0]                  sync2;
    logic [31:0]                  inputs;
    motion_io_pkg::monitor_t      mon;
    logic [7:0]                   outs;
    logic [31:0]                  sel_a;
    logic [31:0]                  sel_b;
    logic [7:0]                   capt_ctrl;
    logic [POS_W-1:0]             capt_axis0;
    logic [POS_W-1:0]             win_low;
    logic [POS_W-1:0]             win_high;
    logic [11:0]                  win_ctrl;
    logic [`IRQ_WIDTH-1:0]        irq_status;
    logic [`IRQ_WIDTH-1:0]        irq_mask;
    logic                         long_active;
    logic                         strap_done;
    logic [17:0]                  cycle_cnt;
    logic                         tick;
    logic                         arm0;
    logic                         arm1;
    logic                         arm2;
    logic                         fwd_hit;
    logic                         rev_hit;
    logic                         irq;
    logic [31:0]                  prdata;
    logic                         pready;
    logic                         pslverr;
  } st_t;
  st_t s_q;
  st_t s_d;
  logic             c0_pulse;
  logic             c1_pulse;
  logic [POS_W-1:0] c0_val;
  logic [POS_W-1:0] c1_val;
  logic             trig0;
  logic             trig1;
  logic [31:0]      raw_in;
  logic             access;
  logic [4:0]       fwd_sel;
  logic [4:0]       rev_sel;
  logic             in_window;
  logic [17:0]      cycle_len;
  logic             long_keep_q = 1'b0;
  // ----------------------------------------
  // Input number space
  // ----------------------------------------
  assign raw_in = {driver_in.servo_on_complete, driver_in.speed_limit_flag, driver_in.current_limit_flag,
                   driver_in.ready, driver_in.rotation_detected, driver_in.speed_conformity,
                   driver_in.warning, driver_in.alarm, 1'b0, driver_in.din,
                   7'h00, encoder_index, local_in}; // see (RULE1) (RULE3) (RULE4)
  assign fwd_sel   = s_q.sel_a[12:8];  // see (RULE2)
  assign rev_sel   = s_q.sel_a[28:24]; // see (RULE2)
  assign in_window = ($signed(axis1_pos) >= $signed(s_q.win_low)) && ($signed(axis1_pos) <= $signed(s_q.win_high));
  assign cycle_len = s_q.long_active ? 18'(CYCLE_LONG - 1) : 18'(CYCLE_SHORT - 1);
  // Source select 0: input 0, 1: input 1, else index; see (RULE8)
  assign trig0 = (s_q.capt_ctrl[2:1] == 2'h0) ? s_q.sync2[0] & ~s_q.inputs[0] :
                 (s_q.capt_ctrl[2:1] == 2'h1) ? s_q.sync2[1] & ~s_q.inputs[1] :
                                                 s_q.sync2[8] & ~s_q.inputs[8];
  assign trig1 = (s_q.capt_ctrl[4:3] == 2'h0) ? s_q.sync2[0] & ~s_q.inputs[0] :
                 (s_q.capt_ctrl[4:3] == 2'h1) ? s_q.sync2[1] & ~s_q.inputs[1] :
                                                 s_q.sync2[8] & ~s_q.inputs[8];
  assign access = psel & penable & ~s_q.pready;
  // Kept through presetn, so a new cycle length waits for the next reset
  always_ff @(posedge pclk) begin
    if (ce && access && pwrite && (paddr == `REG_CYCLE_CFG)) begin
      long_keep_q <= pwdata[0]; // see (RULE15)
    end
  end
  // ----------------------------------------
  // Axis 1 capture pair
  // ----------------------------------------
  capture_unit #(.POS_W(POS_W)) u_capt0 (
    .pclk     (pclk),
    .presetn  (presetn),
    .ce       (ce),
    .arm      (s_q.arm1),
    .trigger  (trig0),
    .position (axis1_pos),
    .captured (c0_pulse),
    .done     (),
    .value    (c0_val)
  ); // see (RULE5) (RULE9)
  capture_unit #(.POS_W(POS_W)) u_capt1 (
    .pclk     (pclk),
    .presetn  (presetn),
    .ce       (ce),
    .arm      (s_q.arm2),
    .trigger  (trig1),
    .position (axis1_pos),
    .captured (c1_pulse),
    .done     (),
    .value    (c1_val)
  ); // see (RULE9)
  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    s_d         = s_q;
    s_d.sync1   = raw_in;
    s_d.sync2   = s_q.sync1;
    s_d.inputs  = s_q.sync2; // see (RULE16)
    s_d.tick    = 1'b0;
    s_d.arm0    = 1'b0;
    s_d.arm1    = 1'b0;
    s_d.arm2    = 1'b0;
    s_d.pready  = 1'b0;
    s_d.pslverr = 1'b0;
    // Cycle length is caught once after reset; later writes wait for the next reset
    if (!s_q.strap_done) begin
      s_d.strap_done  = 1'b1;
      s_d.long_active = long_keep_q; // see (RULE15)
    end
    if (s_q.cycle_cnt == cycle_len) begin
      s_d.cycle_cnt = '0;
      s_d.tick      = 1'b1;
      s_d.mon       = monitor_in; // see (RULE14) (RULE15)
    end else begin
      s_d.cycle_cnt = s_q.cycle_cnt + 18'h00001;
    end
    // Window switching of the selected local outputs; see (RULE11)
    for (int i = 0; i < 6; i++) begin
      if (s_q.win_ctrl[i]) begin
        s_d.outs[2+i] = in_window ? s_q.win_ctrl[6+i] : ~s_q.win_ctrl[6+i];
      end
    end
    // Prohibit inputs act as limits only when both selects point at them; see (RULE10)
    s_d.fwd_hit = (fwd_sel == `IN_FWD_PROHIBIT) && (rev_sel == `IN_REV_PROHIBIT) && s_q.inputs[`IN_FWD_PROHIBIT];
    s_d.rev_hit = (fwd_sel == `IN_FWD_PROHIBIT) && (rev_sel == `IN_REV_PROHIBIT) && s_q.inputs[`IN_REV_PROHIBIT];
    if (s_d.fwd_hit || s_d.rev_hit) begin
      s_d.outs[0] = 1'b0; // Drop the mode select to speed control as a safe state
    end
    if (driver_latch && s_q.capt_ctrl[7]) begin
      s_d.capt_axis0    = driver_latch_pos; // see (RULE6)
      s_d.capt_ctrl[7]  = 1'b0;
    end
    // Bus access: one wait state, answer two cycles after setup
    if (access) begin
      s_d.pready = 1'b1;
      s_d.prdata = 32'h0000_0000;
      if (pwrite) begin
        unique case (paddr)
          `REG_OUTPUTS:      s_d.outs = pwdata[7:0];
          `REG_OUT_SET:      s_d.outs = s_q.outs | pwdata[7:0];
          `REG_OUT_CLR:      s_d.outs = s_q.outs & ~pwdata[7:0];
          `REG_FUNC_SEL_A:   s_d.sel_a = pwdata;
          `REG_FUNC_SEL_B:   s_d.sel_b = pwdata;
          `REG_CAPTURE_CTRL: begin
            s_d.capt_ctrl[6:0] = pwdata[6:0];
            s_d.arm0           = pwdata[8];
            s_d.arm1           = pwdata[9];
            s_d.arm2           = pwdata[10]; // see (RULE5)
            if (pwdata[8]) begin
              s_d.capt_ctrl[7] = 1'b1;
            end
          end
          `REG_WIN_LOW:      s_d.win_low = pwdata[POS_W-1:0];
          `REG_WIN_HIGH:     s_d.win_high = pwdata[POS_W-1:0];
          `REG_WIN_CTRL:     s_d.win_ctrl = pwdata[11:0];
          `REG_IRQ_STATUS:   s_d.irq_status = s_q.irq_status & ~pwdata[`IRQ_WIDTH-1:0];
          `REG_IRQ_MASK:     s_d.irq_mask = pwdata[`IRQ_WIDTH-1:0];
          `REG_CYCLE_CFG:    ;
          `REG_INPUTS:       ; // see (RULE16)
          default:           s_d.pslverr = 1'b1;
        endcase
      end else begin
        unique case (paddr)
          `REG_INPUTS:       s_d.prdata = s_q.inputs; // see (RULE1) (RULE16)
          `REG_OUTPUTS,
          `REG_OUT_SET,
          `REG_OUT_CLR:      s_d.prdata = {24'h000000, s_q.outs};
          `REG_FUNC_SEL_A:   s_d.prdata = s_q.sel_a;
          `REG_FUNC_SEL_B:   s_d.prdata = s_q.sel_b;
          `REG_CAPTURE_CTRL: s_d.prdata = {24'h000000, s_q.capt_ctrl};
          `REG_POS_AXIS0:    s_d.prdata = 32'(axis0_pos);
          `REG_POS_AXIS1:    s_d.prdata = 32'(axis1_pos);
          `REG_CAPT0_AXIS0:  s_d.prdata = 32'(s_q.capt_axis0);
          `REG_CAPT0_AXIS1:  s_d.prdata = 32'(c0_val);
          `REG_CAPT1_AXIS1:  s_d.prdata = 32'(c1_val);
          `REG_CAPT_DIFF:    s_d.prdata = 32'(c1_val - c0_val); // see (RULE9)
          `REG_WIN_LOW:      s_d.prdata = 32'(s_q.win_low);
          `REG_WIN_HIGH:     s_d.prdata = 32'(s_q.win_high);
          `REG_WIN_CTRL:     s_d.prdata = {20'h00000, s_q.win_ctrl};
          `REG_MON_TORQUE:   s_d.prdata = {16'h0000, s_q.mon.torque_command_monitor};
          `REG_MON_SPEED:    s_d.prdata = {16'h0000, s_q.mon.motor_speed_monitor};
          `REG_MON_TVALUE:   s_d.prdata = {16'h0000, s_q.mon.torque_value_monitor};
          `REG_MON_CH0:      s_d.prdata = {16'h0000, s_q.mon.monitor_channel_0};
          `REG_IRQ_STATUS:   s_d.prdata = {26'h0000000, s_q.irq_status};
          `REG_IRQ_MASK:     s_d.prdata = {26'h0000000, s_q.irq_mask};
          `REG_CYCLE_CFG:    s_d.prdata = {30'h00000000, s_q.long_active, long_keep_q};
          default:           s_d.pslverr = 1'b1;
        endcase
      end
    end
    // Events set after the clear so that a set in the clearing cycle wins
    if (driver_latch && s_q.capt_ctrl[7]) s_d.irq_status[`IRQ_CAPT_AXIS0] = 1'b1;
    if (c0_pulse)                           s_d.irq_status[`IRQ_CAPT0_AXIS1] = 1'b1;
    if (c1_pulse)                           s_d.irq_status[`IRQ_CAPT1_AXIS1] = 1'b1;
    if (s_d.fwd_hit && !s_q.fwd_hit)        s_d.irq_status[`IRQ_FWD_LIMIT] = 1'b1;
    if (s_d.rev_hit && !s_q.rev_hit)        s_d.irq_status[`IRQ_REV_LIMIT] = 1'b1;
    if (s_d.tick)                           s_d.irq_status[`IRQ_CYCLE] = 1'b1;
    s_d.irq = |(s_d.irq_status & s_d.irq_mask);
  end
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q       <= '0;
      s_q.sel_a <= `FUNC_SEL_RESET;
      s_q.sel_b <= `FUNC_SEL_RESET;
    end else if (ce) begin
      s_q <= s_d;
    end
  end
  assign prdata                 = s_q.prdata;
  assign pready                 = s_q.pready;
  assign pslverr                = s_q.pslverr;
  assign local_out              = s_q.outs[7:2];        // see (RULE11)
  assign control_mode_select    = s_q.outs[0];          // see (RULE12)
  assign gain_reduce            = s_q.outs[1];          // see (RULE13)
  assign driver_capture_arm     = s_q.arm0;             // see (RULE6)
  assign driver_capture_use_pin = s_q.capt_ctrl[0];     // see (RULE6) (RULE7)
  assign forward_limit_hit      = s_q.fwd_hit;
  assign reverse_limit_hit      = s_q.rev_hit;
  assign cycle_tick             = s_q.tick;
  assign irq                    = s_q.irq;
endmodule : motion_io_map

// ### tb/motion_io_map_chk.sv
/*
 Holds concurrent checks on the ports of the motion I/O map.
 Assumes one clock pclk and presetn as asynchronous active-low reset.
*/
`timescale 1ns/100ps
`include "motion_io_cfg.svh"
module motion_io_map_chk #(
  parameter int CYCLE_SHORT = 20,
  parameter int CYCLE_LONG  = 40
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        ce,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [5:0]  local_out,
  input wire logic        control_mode_select,
  input wire logic        driver_capture_arm,
  input wire logic        forward_limit_hit,
  input wire logic        reverse_limit_hit,
  input wire logic        cycle_tick,
  input wire logic        irq
);
  // ------
  // Servo cycle gap counter
  // ------
  logic [31:0] gap_q;
  logic        seen_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_q  <= 32'h0;
      seen_q <= 1'b0;
    end else if (ce) begin
      gap_q  <= cycle_tick ? 32'h0 : gap_q + 32'h1;
      seen_q <= seen_q | cycle_tick;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ------
  // Properties
  // ------
  sequence s_access_start; $rose(psel && penable) && ce; endsequence
  sequence s_unmapped_rd; psel && penable && !pwrite && pready && (paddr > `REG_CYCLE_CFG); endsequence
  sequence s_inputs_wr; psel && penable && pwrite && pready && (paddr == `REG_INPUTS); endsequence
  chk_ready_answer: assert property (s_access_start |=> pready) else $error("no answer one cycle after access");
  chk_ready_pulse: assert property (pready && ce |=> !pready) else $error("ready held too long");
  chk_err_on_ready: assert property (pslverr |-> pready) else $error("error without ready");
  chk_unmapped_read: assert property (s_unmapped_rd |-> pslverr && prdata == 32'h0)
    else $error("unmapped read not refused");
  chk_input_write: assert property (s_inputs_wr |-> !pslverr) else $error("input write flagged");
  chk_limit_mode: assert property ((forward_limit_hit || reverse_limit_hit) [*3] |-> !control_mode_select)
    else $error("torque mode kept at a limit");
  chk_tick_width: assert property (cycle_tick && ce |=> !cycle_tick) else $error("tick longer than a cycle");
  chk_cycle_gap: assert property (cycle_tick && seen_q |-> gap_q == CYCLE_SHORT - 1 || gap_q == CYCLE_LONG - 1)
    else $error("servo cycle length wrong");
  chk_arm_pulse: assert property (driver_capture_arm && ce |=> !driver_capture_arm) else $error("arm not a pulse");
  chk_freeze_out: assert property (!ce |=> $stable(local_out) && $stable(irq)) else $error("state moved while frozen");
endmodule : motion_io_map_chk
bind motion_io_map motion_io_map_chk #(.CYCLE_SHORT(CYCLE_SHORT), .CYCLE_LONG(CYCLE_LONG)) u_chk (
  .pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .local_out,
  .control_mode_select, .driver_capture_arm, .forward_limit_hit, .reverse_limit_hit, .cycle_tick, .irq);

// ### tb/servo_driver_model.sv
/*
 Holds a behavioural servo driver that answers axis 0 capture requests.
 Assumes arm is a one-cycle pulse on pclk from the motion I/O map.
*/
`timescale 1ns/100ps
module servo_driver_model #(
  parameter logic [31:0] CAPT_POS    = 32'h0000_1234,
  parameter int          DELAY       = 4,
  parameter logic [3:0]  LATCH_ALLOC = 4'h6
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        arm,
  input  wire logic        use_pin,
  output logic             latch,
  output logic      [31:0] latch_pos
);
  int wait_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_q    <= 0;
      latch     <= 1'b0;
      latch_pos <= 32'h0;
    end else begin
      latch     <= 1'b0;
      // Not held outside the pulse; it inverts every cycle, so a wrong sample shows
      latch_pos <= ~latch_pos;
      if (arm) wait_q <= DELAY;
      else if (wait_q > 0) wait_q <= wait_q - 1;
      // Pin capture only with edge code 6 or f; index always
      if (wait_q == 1 && (!use_pin || LATCH_ALLOC == 4'h6 || LATCH_ALLOC == 4'hf)) begin
        latch     <= 1'b1;
        latch_pos <= CAPT_POS;
      end
    end
  end
endmodule : servo_driver_model

// ### tb/motion_io_map_test.sv
/*
 Holds the self-checking bench of the motion I/O map.
 Assumes the design files and the driver model are compiled first.
*/
`timescale 1ns/100ps
`include "motion_io_cfg.svh"
module motion_io_map_test;
  localparam int SHORT = 20;
  localparam int LONG  = 40;
  logic                          pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, err, encoder_index;
  logic                          driver_latch, driver_capture_arm, driver_capture_use_pin, irq, cycle_tick;
  logic                          control_mode_select, gain_reduce, forward_limit_hit, reverse_limit_hit;
  logic [11:0]                   paddr;
  logic [7:0]                    local_in;
  logic [5:0]                    local_out;
  logic [31:0]                   pwdata, prdata, rd, driver_latch_pos, axis0_pos, axis1_pos;
  motion_io_pkg::driver_status_t driver_in;
  motion_io_pkg::monitor_t       monitor_in;
  int                            mismatches, total_checks, n;
  motion_io_map #(.CYCLE_SHORT(SHORT), .CYCLE_LONG(LONG)) dut (.pclk, .presetn, .ce, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .local_in, .encoder_index, .driver_in, .monitor_in, .driver_latch,
    .driver_latch_pos, .axis0_pos, .axis1_pos, .local_out, .control_mode_select, .gain_reduce, .driver_capture_arm,
    .driver_capture_use_pin, .forward_limit_hit, .reverse_limit_hit, .cycle_tick, .irq);
  servo_driver_model drv (.pclk, .presetn, .arm(driver_capture_arm), .use_pin(driver_capture_use_pin),
    .latch(driver_latch), .latch_pos(driver_latch_pos));
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // ------
  // Tasks
  // ------
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic hang(input int k);
    if (k >= 200) begin
      mismatches++;
      print_verdict();
    end
  endtask : hang
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 200);
    hang(n);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask : rd_chk
  task automatic wait_cyc(input int k);
    repeat (k) @(posedge pclk);
  endtask : wait_cyc
  task automatic period(input int exp);
    int k;
    k = 0;
    do begin @(posedge pclk); k++; end while (cycle_tick !== 1'b1 && k < 200);
    hang(k);
    k = 0;
    do begin @(posedge pclk); k++; end while (cycle_tick !== 1'b1 && k < 200);
    check(k, exp);
  endtask : period
  // ------
  // Sequence
  // ------
  initial begin
    {presetn, ce, psel, penable, pwrite, encoder_index} = 6'b010000;
    {paddr, pwdata, local_in, driver_in, monitor_in, axis0_pos, axis1_pos} = '0;
    mismatches = 0;
    total_checks = 0;
    wait_cyc(5);
    presetn <= 1'b1;
    rd_chk(`REG_FUNC_SEL_A, `FUNC_SEL_RESET);
    local_in <= 8'ha5;
    driver_in <= {7'h35, 8'b1001_1010};
    wait_cyc(6);
    rd_chk(`REG_INPUTS, {8'b0101_1001, 1'b0, 7'h35, 8'h00, 8'ha5});
    apb(1'b1, `REG_INPUTS, 32'h0);
    check(err, 1'b0);
    rd_chk(`REG_INPUTS, {8'b0101_1001, 1'b0, 7'h35, 8'h00, 8'ha5});
    {local_in, driver_in} <= '0;
    apb(1'b1, `REG_OUT_SET, 32'hff);
    wait_cyc(2);
    check({local_out, gain_reduce, control_mode_select}, 8'hff);
    apb(1'b1, `REG_OUT_CLR, 32'hfe);
    wait_cyc(2);
    check({local_out, gain_reduce, control_mode_select}, 8'h01);
    rd_chk(`REG_OUTPUTS, 32'h01);
    apb(1'b1, `REG_FUNC_SEL_A, 32'h1300_1200);
    apb(1'b1, `REG_IRQ_MASK, 32'h18);
    for (int k = 0; k < 2; k++) begin
      driver_in.din <= 7'h04 << k;
      wait_cyc(8);
      check({reverse_limit_hit, forward_limit_hit, control_mode_select, irq}, (k == 0) ? 4'h5 : 4'h9);
      apb(1'b1, `REG_IRQ_STATUS, 32'h18);
      wait_cyc(2);
      check(irq, 1'b0);
    end
    driver_in.din <= 7'h00;
    for (int s = 0; s < 3; s++) begin
      axis1_pos <= 32'h100 + s;
      apb(1'b1, `REG_CAPTURE_CTRL, 32'h200 | (s << 1));
      if (s == 2) encoder_index <= 1'b1;
      else local_in[s] <= 1'b1;
      wait_cyc(8);
      rd_chk(`REG_CAPT0_AXIS1, 32'h100 + s);
      encoder_index <= 1'b0;
      local_in <= '0;
      wait_cyc(6);
    end
    apb(1'b1, `REG_CAPTURE_CTRL, 32'h608);
    axis1_pos <= 32'h40;
    local_in <= 8'h01;
    wait_cyc(8);
    axis1_pos <= 32'h70;
    local_in <= 8'h03;
    apb(1'b1, `REG_WIN_HIGH, 32'h80);
    apb(1'b1, `REG_WIN_CTRL, 32'h41);
    rd_chk(`REG_CAPT0_AXIS1, 32'h40);
    rd_chk(`REG_CAPT1_AXIS1, 32'h70);
    rd_chk(`REG_CAPT_DIFF, 32'h30);
    check(local_out, 6'h01);
    axis1_pos <= 32'h90;
    apb(1'b1, `REG_CAPTURE_CTRL, 32'h101);
    wait_cyc(10);
    check(driver_capture_use_pin, 1'b1);
    check(local_out, 6'h00);
    rd_chk(`REG_CAPT0_AXIS0, 32'h0000_1234);
    monitor_in <= {16'h1111, 16'h2222, 16'h3333, 16'h4444};
    period(SHORT);
    wait_cyc(2);
    for (int m = 0; m < 4; m++) rd_chk(`REG_MON_TORQUE + 12'(4 * m), {16'h0, 16'h1111 * (m + 1)});
    apb(1'b0, 12'h0fc, 32'h0);
    check(err, 1'b1);
    check(rd, 32'h0);
    apb(1'b1, `REG_POS_AXIS0, 32'h5);
    check(err, 1'b1);
    ce <= 1'b0;
    wait_cyc(SHORT);
    ce <= 1'b1;
    apb(1'b1, `REG_CYCLE_CFG, 32'h1);
    period(SHORT);
    presetn <= 1'b0;
    wait_cyc(5);
    presetn <= 1'b1;
    period(LONG);
    rd_chk(`REG_FUNC_SEL_A, `FUNC_SEL_RESET);
    print_verdict();
  end
endmodule : motion_io_map_test
